//--- shared/pdt_pkg.sv
package pdt_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int COUNT_W = 8;
    localparam int PRESC_W = 7;
    localparam logic [7:0] COUNT_RESET = 8'hFF;
    localparam logic [6:0] PRESC_RESET = 7'h7F;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam int INT_DIV = 12;

    // ------------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------------
    localparam int ZERO_FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int DIR_BIT = 5;
    localparam int LEVEL_BIT = 4;
    localparam int RUN_BIT = 3;
    localparam int DIV_HI_BIT = 2;
    localparam int DIV_LO_BIT = 0;

    typedef enum logic [1:0] {
        PDT_EVENT,
        PDT_GATED,
        PDT_OUT_LOW,
        PDT_OUT_HIGH
    } pdt_mode_type;

    typedef struct packed {
        logic zero_flag;
        logic zero_irq_enable;
        logic pin_direction_select;
        logic pin_level;
        logic prescaler_run;
        logic [2:0] division_select;
    } pdt_ctrl_type;

    typedef struct packed {
        logic wr_ctrl;
        logic wr_count;
        logic wr_presc;
        logic [7:0] wdata;
    } pdt_wr_type;

endpackage

//--- hdl/pdt_div12.sv
module pdt_div12
    import pdt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic tick
);
    logic [3:0] count;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 4'h0;
            tick <= 1'b0;
        end else begin
            tick <= (count == 4'(INT_DIV - 1));
            count <= (count == 4'(INT_DIV - 1)) ? 4'h0 : count + 4'h1;
        end
    end
endmodule

//--- hdl/pdt_timer.sv
// Summary of operation
// R1 - 8-bit counter fed by 7-bit prescaler.
// R2 - Counter steps on selected tap rising edge.
// R3 - Zero sets flag; enable gives interrupt request.
// R4 - Interrupt request can wake a waiting processor.
// R5 - Prescaler input: internal clock/12 or pin.
// R6 - Division select picks input or prescaler bit.
// R7 - Run low forces prescaler ones, stops all.
// R8 - Prescaler loadable 0 to 7Fh while running.
// R9 - Direction and level bits select four modes.
// R10 - Gated mode counts clock/12 while pin high.
// R11 - Event mode counts pin rising edges.
// R12 - Output mode: flag rise drives level out.
// R13 - Pin latch transparent while flag high.
// R14 - Writing 00h or control bit 7 sets flag.
// R15 - Software clears the flag in its handler.
// R16 - Reset: counter FFh, prescaler 7Fh, control zero.
// R17 - Counter write beats simultaneous decrement to zero.
// R18 - Counter and prescaler readable at any time.
// R19 - Counter wraps from 00h to FFh.
module pdt_timer
    import pdt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire pdt_pkg::pdt_wr_type wr,
    input wire logic timer_pin_in,
    output logic timer_pin_out,
    output logic timer_pin_oe,
    output pdt_pkg::pdt_ctrl_type timer_control_status,
    output logic [7:0] count_value,
    output logic [7:0] prescaler_value,
    output logic timer_irq,
    output logic wake_request
);
    import pdt_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchroniser and internal time base
    // ------------------------------------------------------------------
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic int_tick;
    logic [6:0] presc;
    logic [7:0] count;
    pdt_ctrl_type ctrl;
    logic pin_latch;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_meta <= timer_pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    pdt_div12 u_div12 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick(int_tick)
    );

    // ------------------------------------------------------------------
    // Mode decode and prescaler step
    // ------------------------------------------------------------------
    wire pdt_mode_type mode = pdt_mode_type'({ctrl.pin_direction_select, ctrl.pin_level}); // [R9]
    wire pin_rise = pin_sync & ~pin_prev;
    wire presc_step = ctrl.prescaler_run & ( // [R7]
        (mode == PDT_EVENT) ? pin_rise : // [R11] [R5]
        (mode == PDT_GATED) ? (int_tick & pin_sync) : // [R10]
        int_tick); // [R12]
    wire [6:0] next_presc = presc - 7'h01;
    wire [7:0] tap_vec = {next_presc, presc_step};

    function automatic logic tap_of(input logic [7:0] v, input logic [2:0] sel);
        tap_of = v[sel];
    endfunction

    // Division factor 1 uses the step itself; otherwise the rising edge of a prescaler bit.
    wire [7:0] cur_vec = {presc, 1'b0};
    wire tap_rise = (ctrl.division_select == 3'h0) ? presc_step : // [R6]
        (presc_step & tap_of(tap_vec, ctrl.division_select) &
         ~tap_of(cur_vec, ctrl.division_select));
    wire count_step = tap_rise; // [R2]
    wire [7:0] next_count = count - 8'h01; // [R19]
    wire reach_zero = count_step & (next_count == COUNT_ZERO) & ~wr.wr_count; // [R17]
    wire soft_zero = (wr.wr_count & (wr.wdata == COUNT_ZERO)) |
        (wr.wr_ctrl & wr.wdata[ZERO_FLAG_BIT]); // [R14]

    // ------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc <= PRESC_RESET; // [R16]
        end else if (!ctrl.prescaler_run) begin
            presc <= PRESC_RESET; // [R7]
        end else if (wr.wr_presc) begin
            presc <= wr.wdata[6:0]; // [R8]
        end else if (presc_step) begin
            presc <= next_presc; // [R1]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= COUNT_RESET; // [R16]
        end else if (wr.wr_count) begin
            count <= wr.wdata; // [R17] [R2]
        end else if (count_step) begin
            count <= next_count; // [R2] [R19]
        end
    end

    // ------------------------------------------------------------------
    // Control register; hardware set wins over a software clear
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= pdt_ctrl_type'(CTRL_RESET); // [R16]
        end else begin
            if (wr.wr_ctrl) begin
                ctrl <= pdt_ctrl_type'(wr.wdata);
            end
            if (reach_zero | soft_zero) begin
                ctrl.zero_flag <= 1'b1; // [R3] [R14] [R15]
            end
        end
    end

    // ------------------------------------------------------------------
    // Output latch and registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_latch <= 1'b0;
            timer_pin_out <= 1'b0;
            timer_pin_oe <= 1'b0;
            timer_control_status <= pdt_ctrl_type'(CTRL_RESET);
            count_value <= COUNT_RESET;
            prescaler_value <= {1'b0, PRESC_RESET};
            timer_irq <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            if (ctrl.zero_flag) begin
                pin_latch <= ctrl.pin_level; // [R13] [R12]
            end
            timer_pin_out <= ctrl.zero_flag ? ctrl.pin_level : pin_latch; // [R13]
            timer_pin_oe <= ctrl.pin_direction_select; // [R9]
            timer_control_status <= ctrl;
            count_value <= count; // [R18]
            prescaler_value <= {1'b0, presc}; // [R18]
            timer_irq <= ctrl.zero_flag & ctrl.zero_irq_enable; // [R3]
            wake_request <= ctrl.zero_flag & ctrl.zero_irq_enable; // [R4]
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_run_low_stops: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
        !ctrl.prescaler_run |=> presc == PRESC_RESET && ($stable(count) || $past(wr.wr_count)))
        else $error("prescaler not held while stopped");
    a_zero_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
        reach_zero |=> ctrl.zero_flag)
        else $error("zero reached but flag clear");
    a_write_zero_flag: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
        wr.wr_count && wr.wdata == COUNT_ZERO |=> ctrl.zero_flag && count == COUNT_ZERO)
        else $error("write of zero did not set flag");
    a_write_wins: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
        wr.wr_count && count_step |=> count == $past(wr.wdata))
        else $error("counter write lost to decrement");
    a_wrap_ff: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R19]
        count == COUNT_ZERO && count_step && !wr.wr_count |=> count == COUNT_RESET)
        else $error("counter did not wrap");
    a_irq_follows: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
        ctrl.zero_flag && ctrl.zero_irq_enable |=> timer_irq ##0 wake_request)
        else $error("interrupt request missing");
    a_gated_idle: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
        mode == PDT_GATED && !pin_sync && !wr.wr_presc && ctrl.prescaler_run
        |=> $stable(presc))
        else $error("gated prescaler moved with pin low");
    a_out_level: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
        ctrl.zero_flag |=> timer_pin_out == $past(ctrl.pin_level))
        else $error("pin not transparent while flag high");
    a_presc_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R18]
        1'b1 |=> prescaler_value == {1'b0, $past(presc)})
        else $error("prescaler read stale");

    // ------------------------------------------------------------------
    // Checks on reset and the prescaler inputs
    // ------------------------------------------------------------------
    a_reset_state: assert property (@(posedge ref_clk) // [R16]
        $rose(rst_n)
        |-> count == COUNT_RESET && presc == PRESC_RESET && ctrl == CTRL_RESET)
        else $error("state not at reset values");
    a_run_start: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
        $rose(ctrl.prescaler_run)
        |-> presc == PRESC_RESET)
        else $error("prescaler did not start from all ones");
    a_presc_load: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
        ctrl.prescaler_run && wr.wr_presc
        |=> presc == $past(wr.wdata[6:0]))
        else $error("prescaler load lost");
    a_event_step: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
        mode == PDT_EVENT && ctrl.prescaler_run && $rose(pin_sync) && !wr.wr_presc
        |=> presc == $past(presc) - 7'h01)
        else $error("pin edge not counted");
    a_event_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
        mode == PDT_EVENT && ctrl.prescaler_run && !$rose(pin_sync) && !wr.wr_presc
        |=> $stable(presc))
        else $error("prescaler moved without a pin edge");
    a_gated_step: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
        mode == PDT_GATED && ctrl.prescaler_run && pin_sync && int_tick && !wr.wr_presc
        |=> presc == $past(presc) - 7'h01)
        else $error("gated tick not counted");
    a_out_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12] [R5]
        ctrl.pin_direction_select && ctrl.prescaler_run && !int_tick && !wr.wr_presc
        |=> $stable(presc))
        else $error("output mode prescaler moved between ticks");
    a_out_step: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
        ctrl.pin_direction_select && ctrl.prescaler_run && int_tick && !wr.wr_presc
        |=> presc == $past(presc) - 7'h01)
        else $error("output mode tick not counted");
    a_tick_period: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
        int_tick
        |=> !int_tick [*8] ##1 !int_tick [*3] ##1 int_tick)
        else $error("internal tick not one in twelve");

    // ------------------------------------------------------------------
    // Checks on the counter and zero flag
    // ------------------------------------------------------------------
    a_count_load: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
        wr.wr_count
        |=> count == $past(wr.wdata))
        else $error("counter load lost");
    a_count_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
        !presc_step && !wr.wr_count
        |=> $stable(count))
        else $error("counter moved without a prescaler step");
    a_div_one: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
        ctrl.division_select == 3'h0 && presc_step && !wr.wr_count
        |=> count == $past(count) - 8'h01)
        else $error("factor one step not counted");
    // With a tap above bit 0 the counter must move exactly when the selected
    // prescaler bit rises, and at no other prescaler step.
    a_tap_edge: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
        ctrl.division_select != 3'h0 && presc_step && !wr.wr_count && !wr.wr_presc
        |=> (count != $past(count)) == (presc[$past(ctrl.division_select) - 3'h1] &&
            !$past(presc[ctrl.division_select - 3'h1])))
        else $error("counter not driven by selected tap");
    a_soft_flag: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
        wr.wr_ctrl && wr.wdata[ZERO_FLAG_BIT]
        |=> ctrl.zero_flag)
        else $error("control write did not set flag");
    a_race_no_flag: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
        wr.wr_count && wr.wdata != COUNT_ZERO && !wr.wr_ctrl && !ctrl.zero_flag
        |=> !ctrl.zero_flag)
        else $error("flag set despite counter write");
    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
        ctrl.zero_flag && !wr.wr_ctrl
        |=> ctrl.zero_flag)
        else $error("flag cleared without software");

    // ------------------------------------------------------------------
    // Checks on the pin, interrupt and read-back
    // ------------------------------------------------------------------
    a_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
        !ctrl.zero_flag && $past(!ctrl.zero_flag)
        |=> $stable(timer_pin_out))
        else $error("pin changed while latch closed");
    a_pin_drive: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
        1'b1
        |=> timer_pin_oe == $past(ctrl.pin_direction_select))
        else $error("pin direction wrong");
    a_irq_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3] [R4]
        !(ctrl.zero_flag && ctrl.zero_irq_enable)
        |=> !timer_irq && !wake_request)
        else $error("interrupt request without cause");
    a_count_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R18]
        1'b1
        |=> count_value == $past(count))
        else $error("counter read stale");
    a_status_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R18]
        1'b1
        |=> timer_control_status == $past(ctrl))
        else $error("status read stale");

    // ------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------
    c_zero_hit: cover property (@(posedge ref_clk) disable iff (!rst_n) reach_zero);
    c_gated: cover property (@(posedge ref_clk) disable iff (!rst_n)
        mode == PDT_GATED && presc_step);
    c_event: cover property (@(posedge ref_clk) disable iff (!rst_n)
        mode == PDT_EVENT && count_step);
    c_out_high: cover property (@(posedge ref_clk) disable iff (!rst_n)
        timer_pin_oe && timer_pin_out);
    c_pin_held: cover property (@(posedge ref_clk) disable iff (!rst_n)
        ctrl.pin_direction_select && !ctrl.zero_flag && pin_latch);
endmodule

//--- tb/pdt_pin_model.sv
module pdt_pin_model (
    input wire logic ref_clk,
    input wire logic timer_pin_out,
    input wire logic timer_pin_oe,
    output logic pin_wire
);
    timeunit 1ns;
    timeprecision 1ns;

    logic src_level = 1'b0;

    // The wire follows the timer while it drives, otherwise the external source.
    assign pin_wire = timer_pin_oe ? timer_pin_out : src_level;

    task automatic set_level(input logic lvl);
        @(posedge ref_clk);
        src_level <= lvl;
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            set_level(1'b1);
            repeat (4) @(posedge ref_clk);
            set_level(1'b0);
            repeat (4) @(posedge ref_clk);
        end
    endtask
endmodule

//--- tb/pdt_timer_tb_top.sv
module pdt_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pdt_pkg::*;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    pdt_wr_type wr = '0;
    logic pin_wire;
    logic timer_pin_out;
    logic timer_pin_oe;
    pdt_ctrl_type ctrl;
    logic [7:0] count_value;
    logic [7:0] prescaler_value;
    logic timer_irq;
    logic wake_request;
    int num_errors = 0;
    int check_count = 0;

    pdt_timer pdt_timer_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .wr(wr), .timer_pin_in(pin_wire),
        .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe),
        .timer_control_status(ctrl), .count_value(count_value),
        .prescaler_value(prescaler_value), .timer_irq(timer_irq),
        .wake_request(wake_request)
    );

    pdt_pin_model pdt_pin_model_i (
        .ref_clk(ref_clk), .timer_pin_out(timer_pin_out),
        .timer_pin_oe(timer_pin_oe), .pin_wire(pin_wire)
    );

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Selects 0 control, 1 counter, 2 prescaler; returns once outputs show it.
    task automatic wr_reg(input int sel, input logic [7:0] data);
        @(posedge ref_clk);
        wr <= '{wr_ctrl: sel == 0, wr_count: sel == 1, wr_presc: sel == 2, wdata: data};
        @(posedge ref_clk);
        wr <= '0;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_cyc(1);
        chk("count", count_value, 8'hFF);
        chk("presc", prescaler_value, 8'h7F);
        chk("ctrl", ctrl, 8'h00);
        chk("irq_oe", 8'({timer_irq, wake_request, timer_pin_oe}), 8'h00);
        wr_reg(2, 8'h05);
        chk("presc", prescaler_value, 8'h7F);
        wr_reg(0, 8'h40);
        wr_reg(1, 8'h00);
        chk("ctrl", ctrl, 8'hC0);
        chk("irq", 8'({timer_irq, wake_request}), 8'h03);
        wr_reg(0, 8'h00);
        chk("ctrl", ctrl, 8'h00);
        chk("count", count_value, 8'h00);
        wr_reg(0, 8'h80);
        chk("ctrl", ctrl, 8'h80);
        wr_reg(0, 8'h08);
        wr_reg(2, 8'h05);
        chk("presc", prescaler_value, 8'h05);
        wr_reg(1, 8'h02);
        pdt_pin_model_i.pulse(2);
        wait_cyc(4);
        chk("count", count_value, 8'h00);
        chk("ctrl", ctrl, 8'h88);
        pdt_pin_model_i.pulse(1);
        wait_cyc(4);
        chk("count", count_value, 8'hFF);
        wr_reg(0, 8'h09);
        wr_reg(1, 8'h10);
        pdt_pin_model_i.pulse(4);
        wait_cyc(4);
        chk("count", count_value, 8'h0E);
        wr_reg(0, 8'h0A);
        wr_reg(2, 8'h03);
        wr_reg(1, 8'h10);
        pdt_pin_model_i.pulse(4);
        wait_cyc(4);
        chk("count", count_value, 8'h0F);
        chk("presc", prescaler_value, 8'h7F);
        wr_reg(0, 8'h18);
        wr_reg(1, 8'h40);
        wait_cyc(40);
        chk("count", count_value, 8'h40);
        pdt_pin_model_i.set_level(1'b1);
        wait_cyc(40);
        pdt_pin_model_i.set_level(1'b0);
        wait_cyc(5);
        chk("gated", 8'(count_value inside {8'h3C, 8'h3D}), 8'h01);
        wr_reg(0, 8'h38);
        wr_reg(1, 8'h02);
        wait_cyc(40);
        chk("pin", 8'({ctrl.zero_flag, timer_pin_out, timer_pin_oe}), 8'h07);
        wr_reg(0, 8'h28);
        chk("pin", 8'({ctrl.zero_flag, timer_pin_out, timer_pin_oe}), 8'h03);
        wr_reg(0, 8'hA8);
        chk("pin", 8'({ctrl.zero_flag, timer_pin_out, timer_pin_oe}), 8'h05);
        wr_reg(0, 8'h00);
        wait_cyc(1);
        chk("presc", prescaler_value, 8'h7F);
        finish_test();
    end
endmodule
